// File: iecd_pkg.sv
/*
  shared constants for the input event command decoder: register map,
  outbox and status field positions, command codes, reset values.
  assumes a 32-bit apb slave with byte addresses on an 8-bit paddr.
*/
package iecd_pkg;

  // ==========================================================
  // sizes
  localparam int NCH = 8;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int STS_W = 25;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_OUTBOX = 8'h00;
  localparam logic [7:0] OFS_INBOX = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_CFG_A = 8'h10;
  localparam logic [7:0] OFS_CFG_B = 8'h14;
  localparam logic [7:0] OFS_RSTVAL = 8'h20;
  localparam logic [7:0] OFS_MATCHV = 8'h40;
  localparam logic [7:0] BANK_SPAN = 8'h20;

  // ==========================================================
  // byte lanes of outbox and inbox words
  localparam int LANE_LOW = 0;
  localparam int LANE_HIGH = 8;
  localparam int LANE_CMD = 16;
  localparam int LANE_TOP = 24;

  // ==========================================================
  // status and mask field positions, and the busy bit of cfg b
  localparam int ST_EDGE_LSB = 0;
  localparam int ST_OVF_LSB = 8;
  localparam int ST_MATCH_LSB = 16;
  localparam int ST_PAT_BIT = 24;
  localparam int CFG_BUSY_BIT = 24;

  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_PAT_EN = 8'h21;
  localparam logic [7:0] CMD_PAT_REF = 8'h22;
  localparam logic [7:0] CMD_RISE_EN = 8'h23;
  localparam logic [7:0] CMD_FALL_EN = 8'h24;
  localparam logic [7:0] CMD_CNT_EN = 8'h28;
  localparam logic [7:0] CMD_CNT_LOAD = 8'h29;
  localparam logic [7:0] CMD_OVF_IE = 8'h2a;
  localparam logic [7:0] CMD_MATCH_IE = 8'h2b;

  // ==========================================================
  // reset values and counter maximum
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [15:0] RSTVAL_RESET = 16'h0000;
  localparam logic [15:0] MATCHV_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic {IECD_IDLE, IECD_EXEC} iecd_state_e;

endpackage : iecd_pkg

// File: iecd_chan_if.sv
/*
  carrier for the conditioned input levels and their edge pulses.
  assumes one clock domain on pclk for both ends.
*/
interface iecd_chan_if;
  logic [7:0] level;
  logic [7:0] rise;
  logic [7:0] fall;
  modport src (output level, output rise, output fall);
  modport snk (input level, input rise, input fall);
endinterface : iecd_chan_if

// File: iecd_front.sv
/*
  input front end: three-stage synchroniser per isolated input, a
  level that moves once stages two and three agree, and one-cycle
  rise and fall pulses. assumes pins are asynchronous to pclk.
*/
module iecd_front (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] isolated_input,
  iecd_chan_if.src ch
);

  // ==========================================================
  // per channel synchroniser and edge detect
  for (genvar i = 0; i < iecd_pkg::NCH; i++) begin : g_ch
    logic s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
    logic agree;
    assign agree = (s2_q == s3_q);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        lvl_q <= 1'b0;
        rise_q <= 1'b0;
        fall_q <= 1'b0;
      end else begin
        s1_q <= isolated_input[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        lvl_q <= agree ? s3_q : lvl_q;
        rise_q <= agree & s3_q & ~lvl_q;
        fall_q <= agree & ~s3_q & lvl_q;
      end
    end
    assign ch.level[i] = lvl_q;
    assign ch.rise[i] = rise_q;
    assign ch.fall[i] = fall_q;
  end

endmodule : iecd_front

// File: iecd_top.sv
/*
  input event command decoder: apb slave with an outbox that takes a
  command, an inbox with echo and input levels, per channel counters,
  sticky event status, mask and one interrupt line.
  assumes an apb3 master on pclk and asynchronous isolated inputs.
*/
module iecd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] isolated_input,
  output logic irq
);

  // ==========================================================
  // decoding helpers
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    in_bank = (a >= base) && (a < 8'(base + iecd_pkg::BANK_SPAN)) && (a[1:0] == 2'b00);
  endfunction : in_bank

  iecd_chan_if ch ();

  iecd_front u_front (
    .pclk(pclk),
    .presetn(presetn),
    .isolated_input(isolated_input),
    .ch(ch)
  );

  // ==========================================================
  // state
  iecd_pkg::iecd_state_e state_q, state_d;
  logic pready_q, pslverr_q, irq_q;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0] cmd_q, param_q, phigh_q, top_q;
  logic [7:0] pen_q, pref_q, ren_q, fen_q, cen_q, ovie_q, mie_q;
  logic [7:0] echo_q, inlvl_q;
  logic [iecd_pkg::STS_W-1:0] sts_q, mask_q;
  logic pat_q;
  logic [15:0] cnt_q [iecd_pkg::NCH];
  logic [15:0] rstval_q [iecd_pkg::NCH];
  logic [15:0] matchv_q [iecd_pkg::NCH];

  // ==========================================================
  // apb decode
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready_q;
  wire wr = acc & pwrite;
  wire hit_out = (paddr == iecd_pkg::OFS_OUTBOX);
  wire hit_in = (paddr == iecd_pkg::OFS_INBOX);
  wire hit_sts = (paddr == iecd_pkg::OFS_STATUS);
  wire hit_msk = (paddr == iecd_pkg::OFS_MASK);
  wire hit_cfa = (paddr == iecd_pkg::OFS_CFG_A);
  wire hit_cfb = (paddr == iecd_pkg::OFS_CFG_B);
  wire hit_rv = in_bank(paddr, iecd_pkg::OFS_RSTVAL);
  wire hit_mv = in_bank(paddr, iecd_pkg::OFS_MATCHV);
  wire [2:0] bank_idx = paddr[4:2];
  wire addr_ok = hit_out | hit_in | hit_sts | hit_msk | hit_cfa | hit_cfb | hit_rv | hit_mv;
  wire idle = (state_q == iecd_pkg::IECD_IDLE);
  wire go = wr & hit_out & idle;
  wire busy = ~idle;

  wire [31:0] w_outbox = {top_q, cmd_q, phigh_q, param_q};
  wire [31:0] w_inbox = {inlvl_q, echo_q, 16'h0000};
  wire [31:0] w_cfa = {fen_q, ren_q, pref_q, pen_q};
  wire [31:0] w_cfb = {7'h00, busy, mie_q, ovie_q, cen_q};
  wire [31:0] rd_mux =
    hit_out ? w_outbox :
    hit_in ? w_inbox :
    hit_sts ? {7'h00, sts_q} :
    hit_msk ? {7'h00, mask_q} :
    hit_cfa ? w_cfa :
    hit_cfb ? w_cfb :
    hit_rv ? {16'h0000, rstval_q[bank_idx]} :
    hit_mv ? {16'h0000, matchv_q[bank_idx]} : iecd_pkg::WORD_ZERO;
  assign prdata_d = (setup & ~pwrite) ? rd_mux : prdata_q;

  // ==========================================================
  // command decode
  wire exec = (state_q == iecd_pkg::IECD_EXEC);
  wire do_pen = exec & (cmd_q == iecd_pkg::CMD_PAT_EN);
  wire do_pref = exec & (cmd_q == iecd_pkg::CMD_PAT_REF);
  wire do_ren = exec & (cmd_q == iecd_pkg::CMD_RISE_EN);
  wire do_fen = exec & (cmd_q == iecd_pkg::CMD_FALL_EN);
  wire do_cen = exec & (cmd_q == iecd_pkg::CMD_CNT_EN);
  wire do_load = exec & (cmd_q == iecd_pkg::CMD_CNT_LOAD);
  wire do_ovie = exec & (cmd_q == iecd_pkg::CMD_OVF_IE);
  wire do_mie = exec & (cmd_q == iecd_pkg::CMD_MATCH_IE);
  wire cmd_ok = do_pen | do_pref | do_ren | do_fen | do_cen | do_load | do_ovie | do_mie;
  assign state_d = go ? iecd_pkg::IECD_EXEC : iecd_pkg::IECD_IDLE;

  // ==========================================================
  // pattern match
  wire pat_now = (((ch.level ^ pref_q) & pen_q) == 8'h00) && (pen_q != 8'h00);
  wire pat_ev = pat_now & ~pat_q;

  // ==========================================================
  // counters and events
  logic [7:0] inc, load, ovf_ev, mat_ev, edge_ev;
  logic [15:0] cnt_d [iecd_pkg::NCH];
  for (genvar i = 0; i < iecd_pkg::NCH; i++) begin : g_cnt
    wire [15:0] nxt = cnt_q[i] + 16'h0001;
    assign inc[i] = cen_q[i] & ch.rise[i];
    assign load[i] = do_load & param_q[i];
    assign cnt_d[i] = load[i] ? rstval_q[i] : inc[i] ? nxt : cnt_q[i];
    assign ovf_ev[i] = inc[i] & ~load[i] & (cnt_q[i] == iecd_pkg::CNT_MAX) & ovie_q[i];
    assign mat_ev[i] = inc[i] & ~load[i] & (nxt == matchv_q[i]) & mie_q[i];
    assign edge_ev[i] = (ch.rise[i] & ren_q[i]) | (ch.fall[i] & fen_q[i]);
  end

  wire [iecd_pkg::STS_W-1:0] sts_set = {pat_ev, mat_ev, ovf_ev, edge_ev};
  wire [iecd_pkg::STS_W-1:0] sts_clr = (wr & hit_sts) ? pwdata[iecd_pkg::STS_W-1:0] : '0;
  wire [iecd_pkg::STS_W-1:0] sts_d = (sts_q & ~sts_clr) | sts_set;

  // ==========================================================
  // apb and control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= iecd_pkg::IECD_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= iecd_pkg::WORD_ZERO;
      irq_q <= 1'b0;
      sts_q <= '0;
      mask_q <= '0;
      pat_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pready_q <= setup;
      pslverr_q <= setup & ~addr_ok;
      prdata_q <= prdata_d;
      irq_q <= |(sts_q & mask_q);
      sts_q <= sts_d;
      mask_q <= (wr & hit_msk) ? pwdata[iecd_pkg::STS_W-1:0] : mask_q;
      pat_q <= pat_now;
    end
  end

  // ==========================================================
  // outbox and inbox
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param_q <= 8'h00;
      phigh_q <= 8'h00;
      cmd_q <= 8'h00;
      top_q <= 8'h00;
      echo_q <= 8'h00;
      inlvl_q <= 8'h00;
    end else begin
      if (go) begin
        param_q <= pwdata[iecd_pkg::LANE_LOW +: 8];
        phigh_q <= pwdata[iecd_pkg::LANE_HIGH +: 8];
        cmd_q <= pwdata[iecd_pkg::LANE_CMD +: 8];
        top_q <= pwdata[iecd_pkg::LANE_TOP +: 8];
      end
      echo_q <= cmd_ok ? cmd_q : echo_q;
      inlvl_q <= cmd_ok ? ch.level : inlvl_q;
    end
  end

  // ==========================================================
  // channel configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pen_q <= iecd_pkg::EN_RESET;
      pref_q <= iecd_pkg::EN_RESET;
      ren_q <= iecd_pkg::EN_RESET;
      fen_q <= iecd_pkg::EN_RESET;
      cen_q <= iecd_pkg::EN_RESET;
      ovie_q <= iecd_pkg::EN_RESET;
      mie_q <= iecd_pkg::EN_RESET;
    end else begin
      pen_q <= do_pen ? param_q : pen_q;
      pref_q <= do_pref ? param_q : pref_q;
      ren_q <= do_ren ? param_q : ren_q;
      fen_q <= do_fen ? param_q : fen_q;
      cen_q <= do_cen ? param_q : cen_q;
      ovie_q <= do_ovie ? param_q : ovie_q;
      mie_q <= do_mie ? param_q : mie_q;
    end
  end

  // ==========================================================
  // counter arrays, reset and match values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < iecd_pkg::NCH; i++) begin
        cnt_q[i] <= iecd_pkg::RSTVAL_RESET;
        rstval_q[i] <= iecd_pkg::RSTVAL_RESET;
        matchv_q[i] <= iecd_pkg::MATCHV_RESET;
      end
    end else begin
      for (int i = 0; i < iecd_pkg::NCH; i++) begin
        cnt_q[i] <= cnt_d[i];
      end
      if (wr & hit_rv) begin
        rstval_q[bank_idx] <= pwdata[15:0];
      end
      if (wr & hit_mv) begin
        matchv_q[bank_idx] <= pwdata[15:0];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence cmd_taken_s(logic [7:0] c);
    go && (pwdata[iecd_pkg::LANE_CMD +: 8] == c);
  endsequence

  sequence exec_ok_s;
    exec && cmd_ok;
  endsequence

  sequence rise0_counted_s;
    ch.rise[0] && cen_q[0] && !load[0];
  endsequence

  pat_en_load_a: assert property (
    cmd_taken_s(iecd_pkg::CMD_PAT_EN) |=> ##1 pen_q == $past(pwdata[7:0], 2))
    else $error("pattern enables not loaded");
  pat_ref_load_a: assert property (
    cmd_taken_s(iecd_pkg::CMD_PAT_REF) |=> ##1 pref_q == $past(pwdata[7:0], 2))
    else $error("pattern reference not loaded");
  pat_rise_cause_a: assert property (
    $rose(sts_q[iecd_pkg::ST_PAT_BIT]) |-> $past(((ch.level ^ pref_q) & pen_q) == 8'h00))
    else $error("pattern event without enabled match");
  rise_en_load_a: assert property (
    cmd_taken_s(iecd_pkg::CMD_RISE_EN) |=> ##1 ren_q == $past(pwdata[7:0], 2))
    else $error("rise enables not loaded");
  fall_en_load_a: assert property (
    cmd_taken_s(iecd_pkg::CMD_FALL_EN) |=> ##1 fen_q == $past(pwdata[7:0], 2))
    else $error("fall enables not loaded");
  edge_irq_a: assert property (
    (ch.rise[0] && ren_q[0] && mask_q[0]) |=> sts_q[0] ##1 irq_q)
    else $error("enabled edge gave no interrupt");
  cnt_en_load_a: assert property (
    cmd_taken_s(iecd_pkg::CMD_CNT_EN) |=> ##1 cen_q == $past(pwdata[7:0], 2))
    else $error("counter enables not loaded");
  cnt_reload_a: assert property (
    (do_load && param_q[0]) |=> cnt_q[0] == $past(rstval_q[0]))
    else $error("counter not reloaded");
  ovf_gate_a: assert property (
    $rose(sts_q[iecd_pkg::ST_OVF_LSB]) |-> $past(ovie_q[0]) && $past(cnt_q[0]) == 16'hffff)
    else $error("overflow flag without enable or overflow");
  match_ie_load_a: assert property (
    cmd_taken_s(iecd_pkg::CMD_MATCH_IE) |=> ##1 mie_q == $past(pwdata[7:0], 2))
    else $error("match enables not loaded");
  echo_value_a: assert property (
    exec_ok_s |=> echo_q == $past(cmd_q))
    else $error("command echo wrong");
  level_report_a: assert property (
    exec_ok_s |=> inlvl_q == $past(ch.level))
    else $error("reported levels wrong");
  cnt_step_a: assert property (
    (inc[0] && !load[0]) |=> cnt_q[0] == 16'($past(cnt_q[0]) + 16'h0001))
    else $error("counter did not step by one");
  pen_hold_a: assert property (
    !(exec && cmd_q == iecd_pkg::CMD_PAT_EN) |=> $stable(pen_q))
    else $error("pattern enables changed without command");
  pref_hold_a: assert property (
    !(exec && cmd_q == iecd_pkg::CMD_PAT_REF) |=> $stable(pref_q))
    else $error("pattern reference changed without command");
  ren_hold_a: assert property (
    !(exec && cmd_q == iecd_pkg::CMD_RISE_EN) |=> $stable(ren_q))
    else $error("rise enables changed without command");
  fen_hold_a: assert property (
    !(exec && cmd_q == iecd_pkg::CMD_FALL_EN) |=> $stable(fen_q))
    else $error("fall enables changed without command");
  cen_hold_a: assert property (
    !(exec && cmd_q == iecd_pkg::CMD_CNT_EN) |=> $stable(cen_q))
    else $error("counter enables changed without command");
  mie_hold_a: assert property (
    !(exec && cmd_q == iecd_pkg::CMD_MATCH_IE) |=> $stable(mie_q))
    else $error("match enables changed without command");
  edge_cause_a: assert property (
    $rose(sts_q[iecd_pkg::ST_EDGE_LSB])
      |-> $past((ch.rise[0] && ren_q[0]) || (ch.fall[0] && fen_q[0])))
    else $error("edge flag without enabled edge");
  edge_fall_a: assert property (
    (ch.fall[1] && fen_q[1]) |=> sts_q[iecd_pkg::ST_EDGE_LSB + 1])
    else $error("enabled falling edge not flagged");
  irq_level_a: assert property (
    |(sts_q & mask_q) |=> irq_q)
    else $error("unmasked status gave no interrupt");
  cnt_idle_a: assert property (
    (!cen_q[0] && !load[0]) |=> $stable(cnt_q[0]))
    else $error("disabled counter moved");
  cnt_keep_a: assert property (
    (do_load && !param_q[0] && !inc[0]) |=> $stable(cnt_q[0]))
    else $error("unselected counter reloaded");
  ovf_wrap_a: assert property (
    (rise0_counted_s ##0 (ovie_q[0] && cnt_q[0] == iecd_pkg::CNT_MAX))
      |=> sts_q[iecd_pkg::ST_OVF_LSB] && cnt_q[0] == 16'h0000)
    else $error("enabled overflow not flagged");
  ovf_off_a: assert property (
    (!ovie_q[0] && !sts_q[iecd_pkg::ST_OVF_LSB]) |=> !sts_q[iecd_pkg::ST_OVF_LSB])
    else $error("disabled overflow flagged");
  match_set_a: assert property (
    (rise0_counted_s ##0 (mie_q[0] && 16'(cnt_q[0] + 16'h0001) == matchv_q[0]))
      |=> sts_q[iecd_pkg::ST_MATCH_LSB])
    else $error("enabled value match not flagged");
  match_off_a: assert property (
    (!mie_q[0] && !sts_q[iecd_pkg::ST_MATCH_LSB]) |=> !sts_q[iecd_pkg::ST_MATCH_LSB])
    else $error("disabled value match flagged");
  refuse_keep_a: assert property (
    (exec && !cmd_ok) |=> $stable(echo_q) && $stable(inlvl_q))
    else $error("unknown command changed inbox");
  pat_need_en_a: assert property (
    $rose(sts_q[iecd_pkg::ST_PAT_BIT]) |-> $past(pen_q != 8'h00))
    else $error("pattern event with no channel enabled");
  pat_set_a: assert property (
    ((((ch.level ^ pref_q) & pen_q) == 8'h00) && (pen_q != 8'h00) && !pat_q)
      |=> sts_q[iecd_pkg::ST_PAT_BIT])
    else $error("pattern match not flagged");

endmodule : iecd_top

// File: iecd_host.sv
/*
  host side model: apb master that writes outbox words and reads back.
  assumes callers enter xfer just after a rising pclk edge.
*/
module iecd_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // ==========================================================
  // one transfer, then one idle cycle
  // any address and 32-bit data word, returns prdata and pslverr
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
endmodule : iecd_host

// File: iecd_top_tb.sv
/*
  self-checking bench for the input event command decoder.
  assumes the host model drives the apb side; bench drives the pins.
*/
module iecd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, isolated_input;
  logic [31:0] pwdata, prdata, r;
  logic e;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  typedef struct packed {logic [7:0] c; logic [7:0] p; logic [7:0] ofs; int lsb;} iecd_row_s;
  iecd_row_s rows[8];

  iecd_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .isolated_input(isolated_input), .irq(irq));
  iecd_host h (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==========================================================
  // helpers
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      $display("FAIL %0t timeout", $time);
      end_of_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    h.xfer(1'b1, a, d, r, e);
  endtask : wr

  task rd(input logic [7:0] a);
    h.xfer(1'b0, a, 32'h0000_0000, r, e);
  endtask : rd

  task cmd(input logic [7:0] c, input logic [7:0] p);
    wr(iecd_pkg::OFS_OUTBOX, {8'h00, c, 8'h00, p});
  endtask : cmd

  task pin(input logic [7:0] v);
    isolated_input <= v;
    repeat (6) @(posedge pclk);
  endtask : pin

  task sts(input int lsb, input logic [31:0] m, input logic [31:0] exp);
    rd(iecd_pkg::OFS_STATUS);
    chk((r >> lsb) & m, exp);
    wr(iecd_pkg::OFS_STATUS, 32'h01ff_ffff);
  endtask : sts

  task pulse;
    pin(8'h0c);
    pin(8'h0d);
  endtask : pulse

  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    isolated_input = 8'ha5;
    rows = '{'{iecd_pkg::CMD_PAT_EN, 8'h3a, iecd_pkg::OFS_CFG_A, 0},
      '{iecd_pkg::CMD_PAT_REF, 8'h0a, iecd_pkg::OFS_CFG_A, 8},
      '{iecd_pkg::CMD_RISE_EN, 8'h01, iecd_pkg::OFS_CFG_A, 16},
      '{iecd_pkg::CMD_FALL_EN, 8'h02, iecd_pkg::OFS_CFG_A, 24},
      '{iecd_pkg::CMD_CNT_EN, 8'h01, iecd_pkg::OFS_CFG_B, 0},
      '{iecd_pkg::CMD_CNT_LOAD, 8'h29, iecd_pkg::OFS_INBOX, 16},
      '{iecd_pkg::CMD_OVF_IE, 8'h01, iecd_pkg::OFS_CFG_B, 8},
      '{iecd_pkg::CMD_MATCH_IE, 8'h01, iecd_pkg::OFS_CFG_B, 16}};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(iecd_pkg::OFS_CFG_A);
    chk(r, 32'h0000_0000);
    rd(iecd_pkg::OFS_CFG_B);
    chk(r, 32'h0000_0000);
    rd(iecd_pkg::OFS_MASK);
    chk({r[31:1], irq}, 32'h0000_0000);
    $display("reset test done");
    pin(8'ha5);
    foreach (rows[i]) begin
      cmd(rows[i].c, rows[i].p);
      rd(iecd_pkg::OFS_INBOX);
      chk(r, {8'ha5, rows[i].c, 16'h0000});
      rd(rows[i].ofs);
      chk((r >> rows[i].lsb) & 32'hff, {24'h0, rows[i].p});
    end
    $display("command table done");
    cmd(8'h25, 8'hff);
    rd(iecd_pkg::OFS_INBOX);
    chk(r, {8'ha5, iecd_pkg::CMD_MATCH_IE, 16'h0000});
    rd(8'h18);
    chk({31'h0, e}, 32'h1);
    $display("refusal test done");
    wr(iecd_pkg::OFS_STATUS, 32'h01ff_ffff);
    pin(8'hcf);
    sts(24, 32'h1, 32'h1);
    pin(8'h0a);
    sts(24, 32'h1, 32'h0);
    pin(8'h1a);
    pin(8'h0a);
    sts(24, 32'h1, 32'h1);
    $display("pattern test done");
    wr(iecd_pkg::OFS_MASK, 32'h0000_00ff);
    pin(8'h0b);
    rd(iecd_pkg::OFS_STATUS);
    chk({r[7:0], 7'h0, irq}, 32'h0000_0101);
    wr(iecd_pkg::OFS_STATUS, 32'h0000_0001);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    pin(8'h09);
    pin(8'h0d);
    rd(iecd_pkg::OFS_STATUS);
    chk({r[7:0], 7'h0, irq}, 32'h0000_0201);
    wr(iecd_pkg::OFS_MASK, 32'h0000_0000);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("edge test done");
    wr(iecd_pkg::OFS_RSTVAL, 32'h0000_fffe);
    wr(iecd_pkg::OFS_MATCHV, 32'h0000_ffff);
    cmd(iecd_pkg::CMD_CNT_LOAD, 8'h01);
    wr(iecd_pkg::OFS_STATUS, 32'h01ff_ffff);
    pulse();
    sts(8, 32'hffff, 32'h0100);
    pulse();
    sts(8, 32'hffff, 32'h0001);
    cmd(iecd_pkg::CMD_OVF_IE, 8'h00);
    cmd(iecd_pkg::CMD_CNT_LOAD, 8'h01);
    pulse();
    pulse();
    sts(8, 32'hffff, 32'h0100);
    cmd(iecd_pkg::CMD_CNT_LOAD, 8'h00);
    pulse();
    sts(8, 32'hffff, 32'h0000);
    cmd(iecd_pkg::CMD_CNT_EN, 8'h00);
    cmd(iecd_pkg::CMD_CNT_LOAD, 8'h01);
    pulse();
    sts(8, 32'hffff, 32'h0000);
    rd(iecd_pkg::OFS_INBOX);
    chk(r, {8'h0d, iecd_pkg::CMD_CNT_LOAD, 16'h0000});
    $display("counter test done");
    end_of_test();
  end
endmodule : iecd_top_tb
